/* File: design/scbp_host_port.sv */
// Host bus port and register set of the dual channel serial controller
`timescale 1ns/1ps
// Function
// R1 - Selected read strobe reads and drives bus
// R2 - Vector driven only when highest priority requester
// R3 - Selected store strobe writes addressed register
// R4 - Read plus store strobe means reset
// R5 - Muxed lines carry address then data
// R6 - Address latched on address strobe rising edge
// R7 - First select latched; transfer needs it
// R8 - Host holds second select whole transaction
// R9 - Timing strobe moves data, direction picks
// R10 - Address plus timing strobe means reset
// R11 - Direction line sampled for read or write
// R12 - Sixteen write, eight read registers per channel; code reads nine, data register included
// R13 - Channel B vector readback includes status
// R14 - Pending flags only in channel A
// R15 - Vector and master registers shared
// R16 - Baud divisor written and read bytewise
// R17 - Register zero reports buffer, external status
// R18 - Register zero takes commands and pointer
// R19 - Extended register only on non-muxed variant
// R20 - Status updates itself without host action
// R21 - Polling reads one status register
// R22 - One register shows both channels pending
// R23 - Part select qualifies every access; code skips it for strobe reset and acknowledge cycle
// R24 - Data select high means data transfer
// R25 - Channel select picks channel A or B
// R26 - Acknowledge input sampled on clock edge
// R27 - Pointer write then access, pointer returns
module scbp_host_port #(
  parameter bit MUXED_BUS = 1'b0 // Multiplexed bus variant when set
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [scbp_pkg::DW-1:0] i_bus_data, // Data or muxed address/data lines
  output logic [scbp_pkg::DW-1:0] o_bus_data,
  output logic o_bus_data_oe, // High while driving the lines
  input wire logic i_part_select_n,
  input wire logic i_chan_sel_b,
  input wire logic i_data_cmd_sel,
  input wire logic i_read_strobe_n,
  input wire logic i_store_strobe_n,
  input wire logic i_addr_latch_strobe_n,
  input wire logic i_first_select_n,
  input wire logic i_second_select,
  input wire logic i_transfer_timing_strobe_n,
  input wire logic i_read_not_write,
  input wire logic i_irq_ack_cycle_n,
  input wire logic i_iei,
  input scbp_pkg::scbp_chan_stat_type i_stat_a, // Live channel A status
  input scbp_pkg::scbp_chan_stat_type i_stat_b, // Live channel B status
  input wire logic [scbp_pkg::NUM_SRC-1:0] i_pending, // Pending bits, both channels
  output scbp_pkg::scbp_access_type o_write_evt,
  output logic o_write_evt_vld,
  output scbp_pkg::scbp_access_type o_read_evt,
  output logic o_read_evt_vld,
  output logic o_bus_reset,
  output logic o_ack_taken
);
  import scbp_pkg::*;

  // Pins gathered for synchronising
  logic [SYN_W-1:0] raw_w;
  logic [SYN_W-1:0] syn_w;
  assign raw_w = {i_bus_data, i_part_select_n, i_chan_sel_b, i_data_cmd_sel, i_read_strobe_n,
                  i_store_strobe_n, i_addr_latch_strobe_n, i_first_select_n, i_second_select,
                  i_transfer_timing_strobe_n, i_read_not_write, i_irq_ack_cycle_n, i_iei};

  // Two flip-flops per pin bit before any logic
  for (genvar gi = 0; gi < SYN_W; gi++) begin : g_sync
    logic meta_q;
    logic hold_q;
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
        meta_q <= SYN_IDLE[gi];
        hold_q <= SYN_IDLE[gi];
      end else begin
        meta_q <= raw_w[gi];
        hold_q <= meta_q;
      end
    end
    assign syn_w[gi] = hold_q;
  end

  // Synchronised pin levels
  logic [DW-1:0] s_data;
  logic s_part_n, s_chan_b, s_dc, s_rd_n, s_wr_n, s_as_n;
  logic s_cs0_n, s_cs1, s_ds_n, s_rw, s_ack_n, s_iei;
  assign {s_data, s_part_n, s_chan_b, s_dc, s_rd_n, s_wr_n, s_as_n,
          s_cs0_n, s_cs1, s_ds_n, s_rw, s_ack_n, s_iei} = syn_w;

  // State and held values
  scbp_state_type state_q, state_d; // Bus port state
  logic as_prev_q; // Address strobe one sample back
  logic [DW-1:0] addr_q; // Latched muxed address
  logic cs0_lat_q; // First select latched with address
  logic [PTR_W-1:0] ptr_q; // Register pointer

  // Non-muxed strobe decode
  wire nm_sel_w = ~s_part_n; // R23
  wire nm_rd_w = nm_sel_w & ~s_rd_n & s_wr_n & s_ack_n; // R1
  wire nm_wr_w = nm_sel_w & ~s_wr_n & s_rd_n; // R3
  wire nm_rst_w = ~s_rd_n & ~s_wr_n; // R4
  // Muxed strobe decode
  wire as_rise_w = s_as_n & ~as_prev_q; // R6
  wire mx_go_w = cs0_lat_q & s_cs1 & ~s_ds_n & s_as_n; // R7 R9
  wire mx_rd_w = mx_go_w & s_rw & s_ack_n; // R11
  wire mx_wr_w = mx_go_w & ~s_rw; // R11
  wire mx_rst_w = ~s_as_n & ~s_ds_n; // R10
  // Variant selection
  wire acc_rst_w = MUXED_BUS ? mx_rst_w : nm_rst_w;
  wire acc_rd_w = MUXED_BUS ? mx_rd_w : nm_rd_w;
  wire acc_wr_w = MUXED_BUS ? mx_wr_w : nm_wr_w;
  wire ack_rd_w = ~s_ack_n & (MUXED_BUS ? ~s_ds_n : ~s_rd_n); // R2 R26
  // Addressed channel and register
  wire ch_w = MUXED_BUS ? addr_q[MUX_CH_BIT] : s_chan_b; // R25 R5
  wire [PTR_W-1:0] idx_w = MUXED_BUS ? addr_q[PTR_W-1:0] : (s_dc ? REG_DATA : ptr_q); // R24 R27
  wire is_data_w = (idx_w == REG_DATA);
  wire cmd_w = ~MUXED_BUS & ~s_dc; // Pointer-driven command access

  // Entry and exit events of the state machine
  wire idle_w = (state_q == ST_IDLE);
  wire rst_go_w = (state_q != ST_RESET) & acc_rst_w;
  wire rd_go_w = idle_w & ~acc_rst_w & acc_rd_w;
  wire ack_go_w = idle_w & ~acc_rst_w & ack_rd_w;
  wire wr_go_w = idle_w & ~acc_rst_w & ~ack_rd_w & acc_wr_w;
  wire rd_end_w = (state_q == ST_READ) & ~(acc_rd_w | ack_rd_w);
  wire clr_w = ~i_rst_n | rst_go_w; // R4 R10

  // Highest priority pending source picks the vector code
  logic [VS_W-1:0] code_w;
  always_comb begin
    code_w = VS_NONE;
    for (int k = 0; k < NUM_SRC; k++) begin
      if (i_pending[k]) begin
        code_w = VS_CODE[k];
      end
    end
  end
  wire vec_drive_w = s_iei & (|i_pending); // R2

  // Write register storage, shared ones held in channel A
  logic [DW-1:0] wreg_w [NUM_CH][NUM_REG];
  logic [DW-1:0] ext_w [NUM_CH];
  wire shared_w = (idx_w == REG_VEC) | (idx_w == REG_MASTER); // R15
  wire st_ch_w = shared_w ? CH_A : ch_w; // R15
  wire ext_sel_w = ~MUXED_BUS & (idx_w == REG_EXT) & wreg_w[ch_w][REG_EXTCTL][EXT_SEL_BIT]; // R19

  // One byte per channel and register
  for (genvar gc = 0; gc < NUM_CH; gc++) begin : g_ch
    for (genvar gr = 0; gr < NUM_REG; gr++) begin : g_reg
      logic [DW-1:0] val_q;
      wire we_w = wr_go_w & ~ext_sel_w & (st_ch_w == 1'(gc)) & (idx_w == PTR_W'(gr));
      // Store on the write entry cycle
      always_ff @(posedge i_clk_sys) begin
        if (clr_w) begin
          val_q <= BYTE_ZERO;
        end else if (we_w) begin
          val_q <= s_data; // R3 R12 R16
        end
      end
      assign wreg_w[gc][gr] = val_q;
    end
    logic [DW-1:0] ext_q;
    wire ext_we_w = wr_go_w & ext_sel_w & (ch_w == 1'(gc));
    // Extended overlay on register seven
    always_ff @(posedge i_clk_sys) begin
      if (clr_w) begin
        ext_q <= BYTE_ZERO;
      end else if (ext_we_w) begin
        ext_q <= s_data; // R19
      end
    end
    assign ext_w[gc] = ext_q;
  end

  // Read selection from live status and stored bytes
  scbp_chan_stat_type stat_w;
  assign stat_w = ch_w ? i_stat_b : i_stat_a;
  wire [DW-1:0] vec_base_w = wreg_w[CH_A][REG_VEC];
  wire [DW-1:0] vec_mod_w = (vec_base_w & ~VEC_MASK) | (DW'(code_w) << VEC_LSB); // R13
  wire [DW-1:0] pend_w = (ch_w == CH_A) ? DW'(i_pending) : BYTE_ZERO; // R14 R22
  wire back_w = (idx_w == REG_BAUD_LO) | (idx_w == REG_BAUD_HI) | (idx_w == REG_EXTCTL);
  wire [DW-1:0] rd_byte_w =
    (idx_w == REG_STAT) ? stat_w.buf_ext : // R17 R20 R21
    (idx_w == REG_SPEC) ? stat_w.special :
    (idx_w == REG_VEC) ? ((ch_w == CH_B) ? vec_mod_w : vec_base_w) : // R13
    (idx_w == REG_PEND) ? pend_w : // R14
    (idx_w == REG_DATA) ? stat_w.rx_data :
    (idx_w == REG_MISC) ? stat_w.misc :
    back_w ? wreg_w[ch_w][idx_w] : BYTE_ZERO; // R16
  wire [DW-1:0] pick_w = ack_go_w ? vec_mod_w : rd_byte_w;

  // Next state of the bus port
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (acc_rst_w) state_d = ST_RESET;
        else if (acc_rd_w | ack_rd_w) state_d = ST_READ;
        else if (acc_wr_w) state_d = ST_WRITE;
      end
      ST_READ: begin
        if (acc_rst_w) state_d = ST_RESET;
        else if (~(acc_rd_w | ack_rd_w)) state_d = ST_IDLE;
      end
      ST_WRITE: begin
        if (acc_rst_w) state_d = ST_RESET;
        else if (~acc_wr_w) state_d = ST_IDLE;
      end
      ST_RESET: begin
        if (~acc_rst_w) state_d = ST_IDLE;
      end
    endcase
  end
  wire oe_d = (state_d == ST_READ) & (o_bus_data_oe | rd_go_w | (ack_go_w & vec_drive_w));

  // Muxed address and first select latch
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      as_prev_q <= 1'b1;
      addr_q <= BYTE_ZERO;
      cs0_lat_q <= 1'b0;
    end else begin
      as_prev_q <= s_as_n;
      if (as_rise_w) begin
        addr_q <= s_data; // R6
        cs0_lat_q <= ~s_cs0_n; // R7
      end
    end
  end

  // Register pointer: set by a command write, cleared after use
  wire [PTR_W-1:0] ptr_wr_w = (ptr_q == REG_PTR) ? s_data[PTR_W-1:0] : REG_PTR;
  always_ff @(posedge i_clk_sys) begin
    if (clr_w) begin
      ptr_q <= REG_PTR;
    end else if (wr_go_w & cmd_w) begin
      ptr_q <= ptr_wr_w; // R18 R27
    end else if (rd_end_w & cmd_w) begin
      ptr_q <= REG_PTR; // R27
    end
  end

  // State and bus drivers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      o_bus_data <= BYTE_ZERO;
      o_bus_data_oe <= 1'b0;
    end else begin
      state_q <= state_d;
      o_bus_data_oe <= oe_d; // R1 R2 R9
      if (rd_go_w | ack_go_w) o_bus_data <= pick_w;
    end
  end

  // Event pulses to the channel engines
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_write_evt <= '0;
      o_write_evt_vld <= 1'b0;
      o_read_evt <= '0;
      o_read_evt_vld <= 1'b0;
      o_bus_reset <= 1'b0;
      o_ack_taken <= 1'b0;
    end else begin
      o_write_evt_vld <= wr_go_w; // R3 R18
      o_read_evt_vld <= rd_go_w & is_data_w;
      o_bus_reset <= rst_go_w; // R4 R10
      o_ack_taken <= ack_go_w & vec_drive_w; // R2
      if (wr_go_w) o_write_evt <= '{ch: ch_w, idx: idx_w, is_data: is_data_w, data: s_data};
      if (rd_go_w) o_read_evt <= '{ch: ch_w, idx: idx_w, is_data: is_data_w, data: rd_byte_w};
    end
  end

  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_read_drives_bus: assert property (rd_go_w |=> o_bus_data_oe && o_bus_data == $past(rd_byte_w)) // R1
    else $error("read did not drive the bus");
  a_vector_gated: assert property (ack_go_w && !vec_drive_w |=> !o_bus_data_oe && !o_ack_taken) // R2
    else $error("vector driven without priority");
  a_vector_value: assert property (ack_go_w && vec_drive_w |=> o_bus_data_oe ##0 o_bus_data == $past(vec_mod_w)) // R2
    else $error("wrong acknowledge vector");
  a_write_event: assert property (wr_go_w |=> o_write_evt_vld && o_write_evt.data == $past(s_data)) // R3
    else $error("write not taken");
  a_strobe_reset: assert property (!MUXED_BUS && nm_rst_w && state_q != ST_RESET |=> o_bus_reset ##1 !o_bus_reset) // R4
    else $error("strobe coincidence reset missed");
  a_mux_reset: assert property (MUXED_BUS && mx_rst_w && state_q != ST_RESET |=> o_bus_reset && !o_write_evt_vld) // R10
    else $error("muxed coincidence reset missed");
  a_addr_latch: assert property (as_rise_w |=> addr_q == $past(s_data) && cs0_lat_q == !$past(s_cs0_n)) // R6
    else $error("address not latched");
  a_select_needed: assert property (MUXED_BUS && idle_w && !cs0_lat_q && !ack_rd_w |=> !o_write_evt_vld && !o_bus_data_oe) // R7
    else $error("transfer without first select");
  a_part_select: assert property (!MUXED_BUS && idle_w && s_part_n && !ack_rd_w |=> !o_write_evt_vld && !o_bus_data_oe) // R23
    else $error("access while part deselected");
  a_read_release: assert property (rd_end_w |=> !o_bus_data_oe) // R9
    else $error("drivers held after read");
  a_ptr_return: assert property (wr_go_w && cmd_w && ptr_q != REG_PTR |=> ptr_q == REG_PTR) // R27
    else $error("pointer did not return");
  a_pend_chan_b: assert property (rd_go_w && idx_w == REG_PEND && ch_w == CH_B |=> o_bus_data == BYTE_ZERO) // R14
    else $error("pending flags seen in channel B");
  a_vec_chan_a: assert property (rd_go_w && idx_w == REG_VEC && ch_w == CH_A |=> o_bus_data == $past(vec_base_w)) // R13
    else $error("channel A vector modified");
  c_read: cover property (rd_go_w ##1 o_bus_data_oe);
  c_write: cover property (wr_go_w && cmd_w ##[1:20] wr_go_w);
  c_reset: cover property (rst_go_w);
  c_ack: cover property (ack_go_w && vec_drive_w);
endmodule

/* File: design/scbp_pkg.sv */
// Constants and carrier types of the serial controller host bus port
package scbp_pkg;
  localparam int unsigned DW = 8; // Bus byte width
  localparam int unsigned SYN_W = 20; // Pin bits passing the synchroniser
  localparam logic [SYN_W-1:0] SYN_IDLE = 20'h009EA; // Idle level of each pin bit
  localparam int unsigned PTR_W = 4; // Register pointer width
  localparam int unsigned NUM_CH = 2; // Channels A and B
  localparam int unsigned NUM_REG = 16; // Write registers per channel
  localparam int unsigned NUM_SRC = 6; // Interrupt sources, both channels
  localparam int unsigned VS_W = 3; // Status field inside the vector
  localparam int unsigned MUX_CH_BIT = 4; // Channel bit of the muxed address
  localparam int unsigned EXT_SEL_BIT = 0; // Extended overlay enable in reg 15
  localparam int unsigned VEC_LSB = 1; // Lowest status bit in the vector
  localparam logic [DW-1:0] VEC_MASK = 8'h0E; // Status bits in the vector
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00; // Empty byte
  localparam logic CH_A = 1'b0; // Channel A select
  localparam logic CH_B = 1'b1; // Channel B select
  // Register indices
  localparam logic [PTR_W-1:0] REG_PTR = 4'h0; // Command and pointer / buffer status
  localparam logic [PTR_W-1:0] REG_STAT = 4'h0;
  localparam logic [PTR_W-1:0] REG_SPEC = 4'h1;
  localparam logic [PTR_W-1:0] REG_VEC = 4'h2;
  localparam logic [PTR_W-1:0] REG_PEND = 4'h3;
  localparam logic [PTR_W-1:0] REG_EXT = 4'h7;
  localparam logic [PTR_W-1:0] REG_DATA = 4'h8;
  localparam logic [PTR_W-1:0] REG_MASTER = 4'h9;
  localparam logic [PTR_W-1:0] REG_MISC = 4'hA;
  localparam logic [PTR_W-1:0] REG_BAUD_LO = 4'hC;
  localparam logic [PTR_W-1:0] REG_BAUD_HI = 4'hD;
  localparam logic [PTR_W-1:0] REG_EXTCTL = 4'hF;
  // Vector status codes per pending bit, bit 5 is highest priority
  localparam logic [VS_W-1:0] VS_NONE = 3'h3;
  localparam logic [VS_W-1:0] VS_CODE [NUM_SRC] = '{3'h1, 3'h0, 3'h2, 3'h5, 3'h4, 3'h6};
  // Bus port states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_RESET = 2'b11
  } scbp_state_type;
  // One register access as handed to the channel engines
  typedef struct packed {
    logic ch;
    logic [PTR_W-1:0] idx;
    logic is_data;
    logic [DW-1:0] data;
  } scbp_access_type;
  // Live status of one channel
  typedef struct packed {
    logic [DW-1:0] buf_ext;
    logic [DW-1:0] special;
    logic [DW-1:0] misc;
    logic [DW-1:0] rx_data;
  } scbp_chan_stat_type;
endpackage

/* File: verification/scbp_host_model.sv */
// Host processor model driving the non-multiplexed bus of the port
`timescale 1ns/1ps
module scbp_host_model (
  input wire logic i_clk_sys,
  input wire logic [scbp_pkg::DW-1:0] i_dut_data, // Byte driven by the port
  input wire logic i_dut_oe,
  input wire logic i_wvld,
  input scbp_pkg::scbp_access_type i_wevt,
  input wire logic i_rvld,
  input wire logic i_bus_reset,
  input wire logic i_ack_taken,
  output logic [scbp_pkg::DW-1:0] o_bus_data, // Resolved bus lines
  output logic o_part_select_n,
  output logic o_chan_sel_b,
  output logic o_data_cmd_sel,
  output logic o_read_strobe_n,
  output logic o_store_strobe_n,
  output logic o_irq_ack_cycle_n
);
  import scbp_pkg::*;
  logic drv; // Host drives the lines
  logic [DW-1:0] wv; // Byte the host drives
  scbp_access_type wev; // Last write event seen
  logic revt; // Data read event seen
  logic ack_seen; // Vector hand-over seen
  // Released lines show the inverse, never a stale byte
  assign o_bus_data = i_dut_oe ? i_dut_data : (drv ? wv : ~wv);
  initial begin
    {o_part_select_n, o_irq_ack_cycle_n, o_chan_sel_b, o_data_cmd_sel} = 4'hC;
    {o_read_strobe_n, o_store_strobe_n, drv, wv, wev} = '1;
  end
  // One access; sel is {part_select_n, ack_n, channel, data_select}
  task automatic acc(input logic rd, input logic both, input logic [3:0] sel, input logic [DW-1:0] wd,
                     output logic [DW-1:0] rdat, output logic ok);
    int n;
    @(posedge i_clk_sys);
    #1;
    {o_part_select_n, o_irq_ack_cycle_n, o_chan_sel_b, o_data_cmd_sel} = sel;
    wv = wd;
    drv = !rd;
    o_read_strobe_n = !(rd || both);
    o_store_strobe_n = !(!rd || both);
    {ok, revt, ack_seen, rdat} = '0;
    // Hold everything until the answer edge
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge i_clk_sys);
      revt |= i_rvld;
      ack_seen |= i_ack_taken;
      if (i_wvld) begin
        wev = i_wevt;
      end
      ok = both ? i_bus_reset : (rd ? i_dut_oe : i_wvld);
      rdat = i_dut_data;
    end
    @(posedge i_clk_sys);
    revt |= i_rvld;
    ack_seen |= i_ack_taken;
    #1;
    {o_part_select_n, o_irq_ack_cycle_n, o_read_strobe_n, o_store_strobe_n, drv} = 5'h1E;
    // Strobe released; wait for the port to let go, then two idle cycles
    for (n = 0; n < 8 && i_dut_oe; n++) begin
      @(posedge i_clk_sys);
    end
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
endmodule

/* File: verification/tb.sv */
// Self-checking testbench of the serial controller host bus port
`timescale 1ns/1ps
module tb;
  import scbp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic iei = 1'b1;
  scbp_chan_stat_type stat_a = {8'h81, 24'h000000};
  scbp_chan_stat_type stat_b = {8'h3C, 16'h0000, 8'h77};
  logic [NUM_SRC-1:0] pending = '0;
  logic [DW-1:0] bus_in, dut_data, v;
  logic dut_oe, ps_n, ch_b, dc, rd_n, st_n, ack_n, wvld, rvld, bus_rst, ack_tk, ok;
  scbp_access_type wevt, revt;
  // Multiplexed bus variant, driven by the bench
  logic [DW-1:0] m_data = '0;
  logic [DW-1:0] m_dout;
  logic m_as_n = 1'b1;
  logic m_cs0_n = 1'b1;
  logic m_cs1 = 1'b0;
  logic m_ds_n = 1'b1;
  logic m_rw = 1'b1;
  logic m_oe, m_wvld, m_rst;
  scbp_access_type wevt_m;
  int num_errors = 0;
  int n_tests = 0;
  scbp_host_port dut_u (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_bus_data(bus_in), .o_bus_data(dut_data),
    .o_bus_data_oe(dut_oe), .i_part_select_n(ps_n), .i_chan_sel_b(ch_b), .i_data_cmd_sel(dc),
    .i_read_strobe_n(rd_n), .i_store_strobe_n(st_n), .i_addr_latch_strobe_n(1'b1), .i_first_select_n(1'b1),
    .i_second_select(1'b0), .i_transfer_timing_strobe_n(1'b1), .i_read_not_write(1'b1),
    .i_irq_ack_cycle_n(ack_n), .i_iei(iei), .i_stat_a(stat_a), .i_stat_b(stat_b), .i_pending(pending),
    .o_write_evt(wevt), .o_write_evt_vld(wvld), .o_read_evt(revt), .o_read_evt_vld(rvld),
    .o_bus_reset(bus_rst), .o_ack_taken(ack_tk));
  scbp_host_model host_u (.i_clk_sys(clk_sys), .i_dut_data(dut_data), .i_dut_oe(dut_oe), .i_wvld(wvld),
    .i_wevt(wevt), .i_rvld(rvld), .i_bus_reset(bus_rst), .i_ack_taken(ack_tk), .o_bus_data(bus_in),
    .o_part_select_n(ps_n), .o_chan_sel_b(ch_b), .o_data_cmd_sel(dc), .o_read_strobe_n(rd_n),
    .o_store_strobe_n(st_n), .o_irq_ack_cycle_n(ack_n));
  scbp_host_port #(.MUXED_BUS(1'b1)) dut_m (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_bus_data(m_data),
    .o_bus_data(m_dout), .o_bus_data_oe(m_oe), .i_part_select_n(1'b1), .i_chan_sel_b(1'b0),
    .i_data_cmd_sel(1'b0), .i_read_strobe_n(1'b1), .i_store_strobe_n(1'b1), .i_addr_latch_strobe_n(m_as_n),
    .i_first_select_n(m_cs0_n), .i_second_select(m_cs1), .i_transfer_timing_strobe_n(m_ds_n),
    .i_read_not_write(m_rw), .i_irq_ack_cycle_n(1'b1), .i_iei(1'b1), .i_stat_a(stat_a), .i_stat_b(stat_b),
    .i_pending(6'h00), .o_write_evt(wevt_m), .o_write_evt_vld(m_wvld), .o_read_evt(), .o_read_evt_vld(),
    .o_bus_reset(m_rst), .o_ack_taken());
  // Clock at 100 MHz
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
      num_errors++;
    end
  endtask
  // Vector expected with a status code folded in
  function automatic logic [DW-1:0] vexp(input logic [VS_W-1:0] code);
    return (8'h40 & ~VEC_MASK) | (DW'(code) << VEC_LSB);
  endfunction
  // Pointer write then register write, command side
  task automatic wreg(input logic ch, input logic [PTR_W-1:0] idx, input logic [DW-1:0] val);
    host_u.acc(1'b0, 1'b0, {2'b01, ch, 1'b0}, {4'h0, idx}, v, ok);
    host_u.acc(1'b0, 1'b0, {2'b01, ch, 1'b0}, val, v, ok);
    chk("write taken", ok, 1'b1);
    chk("write event", host_u.wev, {ch, idx, 1'b0, val});
  endtask
  // Pointer write (if not zero) then register read
  task automatic rreg(input logic ch, input logic [PTR_W-1:0] idx, input logic [DW-1:0] exp);
    if (idx != REG_PTR) begin
      host_u.acc(1'b0, 1'b0, {2'b01, ch, 1'b0}, {4'h0, idx}, v, ok);
    end
    host_u.acc(1'b1, 1'b0, {2'b01, ch, 1'b0}, 8'h00, v, ok);
    chk("read drive", ok, 1'b1);
    chk("read byte", v, exp);
  endtask
  // Baud divisor bytes and pointer return
  task automatic t_baud;
    wreg(CH_A, REG_BAUD_LO, 8'h5A);
    wreg(CH_A, REG_BAUD_HI, 8'hA5);
    rreg(CH_A, REG_BAUD_HI, 8'hA5);
    rreg(CH_A, REG_BAUD_LO, 8'h5A);
    rreg(CH_A, REG_STAT, 8'h81);
  endtask
  // Channel choice, live status and data transfers
  task automatic t_chan;
    rreg(CH_B, REG_STAT, 8'h3C);
    stat_b.buf_ext = 8'hC3;
    rreg(CH_B, REG_STAT, 8'hC3);
    host_u.acc(1'b1, 1'b0, 4'h7, 8'h00, v, ok);
    chk("data read", v, 8'h77);
    chk("read event", host_u.revt, 1'b1);
    chk("read event word", revt, {CH_B, REG_DATA, 1'b1, 8'h77});
    host_u.acc(1'b0, 1'b0, 4'h7, 8'h96, v, ok);
    chk("data write", host_u.wev, {CH_B, REG_DATA, 1'b1, 8'h96});
  endtask
  // Shared vector, status-modified readback, pending flags
  task automatic t_vec;
    wreg(CH_B, REG_VEC, 8'h40);
    pending = 6'h20;
    rreg(CH_A, REG_VEC, 8'h40);
    rreg(CH_B, REG_VEC, vexp(VS_CODE[5]));
    pending = 6'h00;
    rreg(CH_B, REG_VEC, vexp(VS_NONE));
    pending = 6'h24;
    rreg(CH_A, REG_PEND, 8'h24);
    rreg(CH_B, REG_PEND, 8'h00);
  endtask
  // Acknowledge cycles with and without priority
  task automatic t_ack;
    pending = 6'h04;
    host_u.acc(1'b1, 1'b0, 4'h8, 8'h00, v, ok);
    chk("ack vector", v, vexp(VS_CODE[2]));
    chk("ack taken", host_u.ack_seen, 1'b1);
    iei = 1'b0;
    host_u.acc(1'b1, 1'b0, 4'h8, 8'h00, v, ok);
    chk("ack blocked", ok, 1'b0);
    iei = 1'b1;
  endtask
  // Unselected strobe and strobe coincidence reset
  task automatic t_refuse;
    host_u.acc(1'b0, 1'b0, 4'hC, 8'h0C, v, ok);
    chk("unselected write", ok, 1'b0);
    host_u.acc(1'b0, 1'b1, 4'h4, 8'h00, v, ok);
    chk("strobe reset", ok, 1'b1);
    rreg(CH_A, REG_BAUD_LO, 8'h00);
  endtask
  // One muxed access: address phase, then data phase
  task automatic m_acc(input logic rw, input logic cs0n, input logic [DW-1:0] addr, input logic [DW-1:0] wd,
                       output logic [DW-1:0] rdat, output logic okm);
    int n;
    @(posedge clk_sys);
    #1;
    {m_as_n, m_cs0_n, m_cs1, m_data} = {1'b0, cs0n, 1'b1, addr};
    repeat (2) @(posedge clk_sys);
    #1;
    m_as_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    {m_data, m_rw, m_ds_n} = {wd, rw, 1'b0};
    okm = 1'b0;
    rdat = '0;
    for (n = 0; n < 8 && !okm; n++) begin
      @(posedge clk_sys);
      okm = rw ? m_oe : m_wvld;
      rdat = m_dout;
    end
    @(posedge clk_sys);
    #1;
    {m_ds_n, m_cs1, m_cs0_n} = 3'b101;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  // Muxed write, readback, refused select and coincidence reset
  task automatic t_mux;
    int n;
    m_acc(1'b0, 1'b0, 8'h1C, 8'h3C, v, ok);
    chk("mux write", ok, 1'b1);
    chk("mux write event", wevt_m, {CH_B, REG_BAUD_LO, 1'b0, 8'h3C});
    m_acc(1'b1, 1'b0, 8'h1C, 8'h00, v, ok);
    chk("mux read", v, 8'h3C);
    m_acc(1'b0, 1'b1, 8'h1C, 8'hFF, v, ok);
    chk("mux unselected", ok, 1'b0);
    m_acc(1'b1, 1'b0, 8'h1C, 8'h00, v, ok);
    chk("mux kept", v, 8'h3C);
    @(posedge clk_sys);
    #1;
    {m_as_n, m_ds_n} = 2'b00;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge clk_sys);
      ok = m_rst;
    end
    #1;
    {m_as_n, m_ds_n} = 2'b11;
    repeat (6) @(posedge clk_sys);
    #1;
    chk("mux reset", ok, 1'b1);
    m_acc(1'b1, 1'b0, 8'h1C, 8'h00, v, ok);
    chk("mux cleared", v, 8'h00);
  endtask
  // Verdict and end of run
  task automatic results;
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200000;
    num_errors++;
    results();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk("idle drive", dut_oe, 1'b0);
    t_baud();
    t_chan();
    t_vec();
    t_ack();
    t_refuse();
    t_mux();
    results();
  end
endmodule
